/* File: bench/sys_host.sv */
// system processor model: master of the serial register port
// assumes pull-ups on scl and sda; sda is the resolved wire level
module sys_host #(
  parameter logic [6:0] ADDR = adc_irq_pkg::DEVICE_ADDR_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // bit level, 16 clk per bit, data changes only with scl low
  // ----
  logic [7:0] rd_data;
  logic rx_busy;
  event rd_done;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    rx_busy = 1'b0;
  end
  task automatic q();
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic put(input logic b);
    sda_low = !b;
    q();
    scl = 1'b1;
    q();
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic get(output logic b);
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    b = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  task automatic tx(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--)
      put(d[i]);
    get(a);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    start();
    tx({ADDR, 1'b0});
    tx(p);
    tx(d);
    stop();
  endtask
  // reading the request byte is how the source is learned
  task automatic rd(input logic [7:0] p);
    logic [7:0] d;
    start();
    tx({ADDR, 1'b0});
    tx(p);
    start();
    tx({ADDR, 1'b1});
    rx_busy = 1'b1;
    for (int i = 7; i >= 0; i--)
      get(d[i]);
    rx_busy = 1'b0;
    put(1'b1);
    stop();
    rd_data = d;
    -> rd_done;
  endtask
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the converter control and interrupt unit
// assumes the processor model on the serial port; pull-ups on sda and request pin
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_irq_pkg::*;
  localparam int LIMIT = 80000;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic adapter_present = 1'b0;
  logic usb_present = 1'b0;
  logic battery_low = 1'b0;
  logic thermal_alarm = 1'b0;
  logic charge_timeout = 1'b0;
  logic adc_cmp_high = 1'b0;
  logic scl, sda_low, sda_out, sda_oe, irq_out_n, irq_out_n_oe, adc_enable;
  logic battery_voltage_span_sel, charge_current_span_sel, adc_integrate, adc_deintegrate;
  logic [1:0] adc_source_sel;
  logic [7:0] exp_q[$];
  logic [7:0] m;
  int seed = 32'h3e90;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  wire logic sda = !(sda_low || sda_oe);
  wire logic irq_line = !irq_out_n_oe;
  always #50 clk_sys = !clk_sys;
  adc_irq_unit #(.WARM_CYC(40), .INT_CYC(40), .STEP_CYC(2)) u_adc_irq_unit (
    .clk_sys, .srst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .irq_out_n_in(irq_line), .irq_out_n, .irq_out_n_oe, .adapter_present,
    .usb_present, .battery_low, .thermal_alarm, .charge_timeout, .adc_cmp_high,
    .adc_enable, .adc_source_sel, .battery_voltage_span_sel, .charge_current_span_sel,
    .adc_integrate, .adc_deintegrate);
  sys_host u_sys_host (.clk_sys, .sda, .scl, .sda_low);
  // ----
  // helpers
  // ----
  task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    u_sys_host.rd(p);
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wait_irq();
    int k = 0;
    while (irq_out_n_oe !== 1'b1 && k < 2000)
    begin
      w(1);
      k++;
    end
  endtask
  always @(u_sys_host.rd_done)
    check("read", u_sys_host.rd_data, exp_q.pop_front());
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  // ----
  // scenarios
  // ----
  initial
  begin
    w(4);
    srst = 1'b0;
    w(4);
    rd(CONTROL_OFFSET, CONTROL_RESET);
    rd(RESULT_OFFSET, RESULT_RESET);
    rd(MASK_OFFSET, MASK_RESET);
    rd(REQUEST_OFFSET, REQUEST_RESET);
    rd(8'h20, UNMAPPED_READ);
    check("enable", 8'(adc_enable), 8'h00);
    check("drive", {6'h00, sda_out, irq_out_n}, 8'h00);
    $display("test reset done");
    for (int s = 0; s < 4; s++)
    begin
      m = {s[1:0], 4'h0, s[1:0]};
      u_sys_host.wr(CONTROL_OFFSET, m);
      rd(CONTROL_OFFSET, m);
      check("sel", 8'(adc_source_sel), 8'(s));
      check("vspan", 8'(battery_voltage_span_sel), 8'(s[1]));
      check("ispan", 8'(charge_current_span_sel), 8'(s[0]));
    end
    $display("test control done");
    adc_cmp_high = 1'b1;
    u_sys_host.wr(MASK_OFFSET, 8'h40);
    u_sys_host.wr(CONTROL_OFFSET, 8'h04);
    check("enable", 8'(adc_enable), 8'h01);
    u_sys_host.wr(CONTROL_OFFSET, 8'h0c);
    check("integ", 8'(adc_integrate), 8'h01);
    w(30);
    check("deint", 8'(adc_deintegrate), 8'h01);
    wait_irq();
    check("irq", 8'(irq_out_n_oe), 8'h01);
    rd(CONTROL_OFFSET, 8'h3c);
    rd(RESULT_OFFSET, 8'hff);
    rd(REQUEST_OFFSET, 8'h40);
    w(8);
    check("irq", 8'(irq_out_n_oe), 8'h00);
    adc_cmp_high = 1'b0;
    u_sys_host.wr(CONTROL_OFFSET, 8'h06);
    u_sys_host.wr(CONTROL_OFFSET, 8'h0e);
    wait_irq();
    rd(CONTROL_OFFSET, 8'h1e);
    rd(RESULT_OFFSET, 8'h00);
    rd(REQUEST_OFFSET, 8'h40);
    $display("test conversion done");
    for (int i = 0; i < 8; i++)
    begin
      if (i == 6)
        continue;
      m = 8'($random(seed));
      // one source surely unmasked, one surely masked
      m[ADAPTER_ATTACH_BIT] = 1'b1;
      m[BATTERY_LOW_BIT] = 1'b0;
      u_sys_host.wr(MASK_OFFSET, m);
      case (i)
        0, 1: adapter_present = (i == 0);
        2, 3: usb_present = (i == 2);
        4: battery_low = 1'b1;
        5: thermal_alarm = 1'b1;
        default: charge_timeout = 1'b1;
      endcase
      w(10);
      check("irq", 8'(irq_out_n_oe), 8'(m[i]));
      rd(REQUEST_OFFSET, 8'(1 << i));
      w(8);
      check("irq", 8'(irq_out_n_oe), 8'h00);
    end
    $display("test sources done");
    battery_low = 1'b0;
    thermal_alarm = 1'b0;
    w(10);
    u_sys_host.wr(MASK_OFFSET, 8'hff);
    battery_low = 1'b1;
    w(10);
    fork
      rd(REQUEST_OFFSET, 8'h10);
      begin
        wait (u_sys_host.rx_busy === 1'b1);
        w(20);
        thermal_alarm = 1'b1;
      end
    join
    w(4);
    check("irq", 8'(irq_out_n_oe), 8'h01);
    rd(REQUEST_OFFSET, 8'h20);
    $display("test pending done");
    stop_test();
  end
endmodule

/* File: rtl/adc_irq_pkg.sv */
// constants, field layout and state types of the converter control and interrupt unit
// assumes a 10 MHz system clock and a serial register port sampled on it
package adc_irq_pkg;

  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_OFFSET = 8'h0a;
  localparam logic [7:0] RESULT_OFFSET = 8'h0b;
  localparam logic [7:0] MASK_OFFSET = 8'h0c;
  localparam logic [7:0] REQUEST_OFFSET = 8'h0d;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] REQUEST_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // converter_control fields
  // ----------------------------------------------------------------
  localparam int VSPAN_BIT = 7;
  localparam int ISPAN_BIT = 6;
  localparam int OVERFLOW_BIT = 5;
  localparam int READY_BIT = 4;
  localparam int START_BIT = 3;
  localparam int ENABLE_BIT = 2;
  localparam int SEL_MSB = 1;
  localparam int SEL_LSB = 0;

  // source selector codes
  localparam logic [1:0] SRC_BATTERY_VOLTAGE = 2'h0;
  localparam logic [1:0] SRC_CHARGE_CURRENT = 2'h1;
  localparam logic [1:0] SRC_EXT_INPUT_A = 2'h2;
  localparam logic [1:0] SRC_EXT_INPUT_B = 2'h3;

  // ----------------------------------------------------------------
  // interrupt source positions
  // ----------------------------------------------------------------
  localparam int ADAPTER_ATTACH_BIT = 0;
  localparam int ADAPTER_REMOVE_BIT = 1;
  localparam int USB_ATTACH_BIT = 2;
  localparam int USB_REMOVE_BIT = 3;
  localparam int BATTERY_LOW_BIT = 4;
  localparam int THERMAL_ALARM_BIT = 5;
  localparam int CONVERSION_DONE_BIT = 6;
  localparam int CHARGE_TIMEOUT_BIT = 7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int WARMUP_TIME_US = 2000;
  localparam int INTEGRATE_TIME_US = 2000;
  localparam int DEINTEGRATE_MAX_US = 2000;
  localparam int CODE_STEPS = 256;
  localparam int WARMUP_CYC = WARMUP_TIME_US * (CLK_HZ / 1_000_000);
  localparam int INTEGRATE_CYC = INTEGRATE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int DEINTEGRATE_CYC = DEINTEGRATE_MAX_US * (CLK_HZ / 1_000_000);
  localparam int STEP_CYC = DEINTEGRATE_CYC / CODE_STEPS;

  // serial port device address
  localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h3c;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SP_IDLE = 3'h0,
    SP_ADDR = 3'h1,
    SP_ADDR_ACK = 3'h3,
    SP_WRITE = 3'h2,
    SP_WRITE_ACK = 3'h6,
    SP_READ = 3'h7,
    SP_READ_ACK = 3'h5
  } port_state_t;

  typedef enum logic [2:0] {
    CV_OFF = 3'h0,
    CV_WARM = 3'h1,
    CV_READY = 3'h3,
    CV_INTEG = 3'h2,
    CV_DEINT = 3'h6
  } conv_state_t;

endpackage

/* File: rtl/adc_irq_unit.sv */
// converter control registers and eight-source interrupt unit behind a serial port
// assumes scl/sda and status pins are asynchronous; open-drain pins resolved outside
// What this block does
// [RL1] D7 selects narrow or wide battery span
// [RL2] D6 selects 605 or 1100 mA span
// [RL3] battery code zero is 2.6 V
// [RL4] external inputs unscaled, code zero is reference
// [RL5] D1-0 select the converted source
// [RL6] converter disabled after reset, D2 enables
// [RL7] writing one to D3 starts conversion
// [RL8] host toggles start bit zero then one
// [RL9] host selects source before starting
// [RL10] completion sets D4 and conversion event
// [RL11] unmasked events pull interrupt pin low
// [RL12] masked events still recorded for polling
// [RL13] mask bit one enables, resets to zero
// [RL14] reading request register clears it
// [RL15] events during clear held in pending buffer
// [RL16] pending event re-asserts pin at once
// [RL17] no priority, firmware orders service
// [RL18] events captured regardless of standby
// [RL19] attach and removal events for both inputs
// [RL20] battery low raises its event
// [RL21] thermal alarm raises its event
// [RL22] charger timeout raises its event
// [RL23] request register one bit per source
module adc_irq_unit #(
  parameter logic [6:0] DEV_ADDR = adc_irq_pkg::DEVICE_ADDR_DEFAULT,
  parameter int WARM_CYC = adc_irq_pkg::WARMUP_CYC,
  parameter int INT_CYC = adc_irq_pkg::INTEGRATE_CYC,
  parameter int STEP_CYC = adc_irq_pkg::STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic irq_out_n_in,
  output logic irq_out_n,
  output logic irq_out_n_oe,
  input wire logic adapter_present,
  input wire logic usb_present,
  input wire logic battery_low,
  input wire logic thermal_alarm,
  input wire logic charge_timeout,
  input wire logic adc_cmp_high,
  output logic adc_enable,
  output logic [1:0] adc_source_sel,
  output logic battery_voltage_span_sel,
  output logic charge_current_span_sel,
  output logic adc_integrate,
  output logic adc_deintegrate
);
  import adc_irq_pkg::*;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // pin synchronisation and edges
  // ----------------------------------------------------------------
  logic [7:0] pins_f;
  logic [7:0] pins_d_reg;
  logic scl_f, sda_f, scl_d, sda_d;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] ev;
  logic conv_done, conv_ovf, conv_busy;
  logic [7:0] conv_code;

  pin_sync #(.W(8), .INIT(8'h03)) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d({adc_cmp_high, charge_timeout, thermal_alarm, battery_low, usb_present,
        adapter_present, sda_in, scl_in}),
    .q(pins_f)
  );

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pins_d_reg <= 8'h03;
    else
      pins_d_reg <= pins_f;
  end

  assign scl_f = pins_f[0];
  assign sda_f = pins_f[1];
  assign scl_d = pins_d_reg[0];
  assign sda_d = pins_d_reg[1];
  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start_c = scl_f & scl_d & sda_d & ~sda_f;
  assign stop_c = scl_f & scl_d & ~sda_d & sda_f;

  // event vector, one bit per source
  always_comb
  begin
    ev = 8'h00;
    ev[ADAPTER_ATTACH_BIT] = pins_f[2] & ~pins_d_reg[2]; // RL19
    ev[ADAPTER_REMOVE_BIT] = ~pins_f[2] & pins_d_reg[2]; // RL19
    ev[USB_ATTACH_BIT] = pins_f[3] & ~pins_d_reg[3]; // RL19
    ev[USB_REMOVE_BIT] = ~pins_f[3] & pins_d_reg[3]; // RL19
    ev[BATTERY_LOW_BIT] = pins_f[4] & ~pins_d_reg[4]; // RL20
    ev[THERMAL_ALARM_BIT] = pins_f[5] & ~pins_d_reg[5]; // RL21
    ev[CONVERSION_DONE_BIT] = conv_done; // RL10
    ev[CHARGE_TIMEOUT_BIT] = pins_f[6] & ~pins_d_reg[6]; // RL22
  end

  // ----------------------------------------------------------------
  // serial register port
  // ----------------------------------------------------------------
  port_state_t st_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg, ptr_reg, rdata;
  logic rw_reg, first_reg, ack_ok_reg;
  logic rd_load, rd_end, wr_stb;

  logic vspan_reg, ispan_reg, ovf_reg, ready_reg, start_reg, en_reg;
  logic [1:0] sel_reg;
  logic [7:0] result_reg, mask_reg, req_reg, pend_reg;
  logic clr_busy_reg, clr_start, clr_end, start_pulse;

  assign rd_load = scl_fall && ((st_reg == SP_ADDR_ACK && rw_reg)
                   || (st_reg == SP_READ_ACK && ack_ok_reg));
  assign rd_end = scl_fall && st_reg == SP_READ && cnt_reg == 4'h8;
  assign wr_stb = scl_fall && st_reg == SP_WRITE && cnt_reg == 4'h8 && !first_reg;

  always_comb
  begin
    case (ptr_reg)
      CONTROL_OFFSET: rdata = {vspan_reg, ispan_reg, ovf_reg, ready_reg, start_reg,
                               en_reg, sel_reg};
      RESULT_OFFSET: rdata = result_reg;
      MASK_OFFSET: rdata = mask_reg;
      REQUEST_OFFSET: rdata = req_reg; // RL23
      default: rdata = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_reg <= SP_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (start_c)
    begin
      st_reg <= SP_ADDR;
      cnt_reg <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (stop_c)
    begin
      st_reg <= SP_IDLE;
      sda_oe <= 1'b0;
    end
    else if (scl_rise)
    begin
      case (st_reg)
        SP_ADDR, SP_WRITE:
        begin
          shift_reg <= {shift_reg[6:0], sda_f};
          cnt_reg <= cnt_reg + 4'h1;
        end
        SP_READ: cnt_reg <= cnt_reg + 4'h1;
        SP_READ_ACK: ack_ok_reg <= ~sda_f;
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (st_reg)
        SP_ADDR:
        begin
          if (cnt_reg == 4'h8)
          begin
            if (shift_reg[7:1] == DEV_ADDR)
            begin
              st_reg <= SP_ADDR_ACK;
              rw_reg <= shift_reg[0];
              sda_oe <= 1'b1;
            end
            else
              st_reg <= SP_IDLE;
          end
        end
        SP_WRITE:
        begin
          if (cnt_reg == 4'h8)
          begin
            st_reg <= SP_WRITE_ACK;
            sda_oe <= 1'b1;
            first_reg <= 1'b0;
            ptr_reg <= first_reg ? shift_reg : ptr_reg + 8'h01;
          end
        end
        SP_WRITE_ACK:
        begin
          st_reg <= SP_WRITE;
          cnt_reg <= 4'h0;
          sda_oe <= 1'b0;
        end
        SP_READ:
        begin
          if (cnt_reg == 4'h8)
          begin
            st_reg <= SP_READ_ACK;
            sda_oe <= 1'b0;
          end
          else
          begin
            sda_oe <= ~shift_reg[6];
            shift_reg <= {shift_reg[6:0], 1'b0};
          end
        end
        SP_ADDR_ACK, SP_READ_ACK:
        begin
          cnt_reg <= 4'h0;
          if (rd_load)
          begin
            st_reg <= SP_READ;
            shift_reg <= rdata;
            sda_oe <= ~rdata[7];
            ptr_reg <= ptr_reg + 8'h01;
          end
          else if (st_reg == SP_ADDR_ACK)
          begin
            st_reg <= SP_WRITE;
            first_reg <= 1'b1;
            sda_oe <= 1'b0;
          end
          else
            st_reg <= SP_IDLE;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // converter control
  // ----------------------------------------------------------------
  assign start_pulse = wr_stb && ptr_reg == CONTROL_OFFSET
                       && shift_reg[START_BIT] && !start_reg; // RL7 RL8

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      {vspan_reg, ispan_reg, ovf_reg, ready_reg, start_reg, en_reg, sel_reg} <=
        CONTROL_RESET; // RL6
      result_reg <= RESULT_RESET;
      mask_reg <= MASK_RESET; // RL13
    end
    else
    begin
      if (wr_stb && ptr_reg == CONTROL_OFFSET)
      begin
        vspan_reg <= shift_reg[VSPAN_BIT]; // RL1
        ispan_reg <= shift_reg[ISPAN_BIT]; // RL2
        start_reg <= shift_reg[START_BIT];
        en_reg <= shift_reg[ENABLE_BIT]; // RL6
        sel_reg <= shift_reg[SEL_MSB:SEL_LSB]; // RL5
      end
      if (wr_stb && ptr_reg == MASK_OFFSET)
        mask_reg <= shift_reg; // RL13
      // completion wins over the clear from a new start
      if (conv_done)
      begin
        ready_reg <= 1'b1; // RL10
        ovf_reg <= conv_ovf;
        result_reg <= conv_code; // RL3 RL4
      end
      else if (start_pulse)
        ready_reg <= 1'b0;
    end
  end

  conv_seq #(.WARM_CYC(WARM_CYC), .INT_CYC(INT_CYC), .STEP_CYC(STEP_CYC)) u_conv (
    .clk_sys(clk_sys),
    .srst(srst),
    .enable(en_reg),
    .start(start_pulse),
    .cmp_high(pins_f[7]),
    .integ(adc_integrate),
    .deint(adc_deintegrate),
    .busy(conv_busy),
    .done(conv_done),
    .ovf(conv_ovf),
    .code(conv_code)
  );

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      adc_enable <= 1'b0;
      adc_source_sel <= SRC_BATTERY_VOLTAGE;
      battery_voltage_span_sel <= 1'b0;
      charge_current_span_sel <= 1'b0;
    end
    else
    begin
      adc_enable <= en_reg;
      adc_source_sel <= sel_reg; // RL5
      battery_voltage_span_sel <= vspan_reg; // RL1
      charge_current_span_sel <= ispan_reg; // RL2
    end
  end

  // ----------------------------------------------------------------
  // interrupt request, pending buffer and pin
  // ----------------------------------------------------------------
  assign clr_start = rd_load && ptr_reg == REQUEST_OFFSET; // RL14
  assign clr_end = clr_busy_reg && (rd_end || start_c || stop_c);

  // capture has no standby gating
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      req_reg <= REQUEST_RESET; // RL23
      pend_reg <= 8'h00;
      clr_busy_reg <= 1'b0;
    end
    else if (clr_start)
    begin
      req_reg <= 8'h00; // RL14
      pend_reg <= pend_reg | ev; // RL15
      clr_busy_reg <= 1'b1;
    end
    else if (clr_end)
    begin
      req_reg <= pend_reg | ev; // RL15
      pend_reg <= 8'h00;
      clr_busy_reg <= 1'b0;
    end
    else if (clr_busy_reg)
      pend_reg <= pend_reg | ev; // RL15
    else
      req_reg <= req_reg | ev; // RL12 RL18
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      irq_out_n <= 1'b0;
      irq_out_n_oe <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      irq_out_n <= 1'b0;
      sda_out <= 1'b0;
      irq_out_n_oe <= |(req_reg & mask_reg); // RL11 RL13 RL16
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_irq_follows_mask: assert property ( // RL11
    irq_out_n_oe == $past(|(req_reg & mask_reg))) else $error("irq pin not mask gated");
  a_masked_still_kept: assert property ( // RL12
    ev[BATTERY_LOW_BIT] && !mask_reg[BATTERY_LOW_BIT] && !clr_busy_reg && !clr_start
    |=> req_reg[BATTERY_LOW_BIT]) else $error("masked event not recorded");
  a_reset_defaults: assert property ( // RL13
    $fell(srst) |-> mask_reg == 8'h00 && !en_reg && req_reg == 8'h00)
    else $error("reset values wrong");
  a_read_clears_req: assert property ( // RL14
    clr_start |=> req_reg == 8'h00 ##1 !irq_out_n_oe) else $error("request not cleared");
  a_pending_holds: assert property ( // RL15
    clr_busy_reg && !clr_end && ev != 8'h00 |=> pend_reg != 8'h00)
    else $error("event lost during clear");
  a_pending_reasserts: assert property ( // RL16
    clr_end && ((pend_reg | ev) & mask_reg) != 8'h00 |=> ##1 irq_out_n_oe)
    else $error("pending event did not re-assert pin");
  a_start_launches: assert property ( // RL7
    start_pulse && en_reg && u_conv.st_reg == CV_READY |=> ##1 adc_integrate)
    else $error("start did not launch conversion");
  a_done_flags: assert property ( // RL10
    conv_done && !clr_busy_reg && !clr_start
    |=> ready_reg && req_reg[CONVERSION_DONE_BIT] && result_reg == $past(conv_code))
    else $error("completion not flagged");
  a_attach_event: assert property ( // RL19
    $rose(pins_f[2]) && !clr_busy_reg && !clr_start |=> req_reg[ADAPTER_ATTACH_BIT])
    else $error("adapter attach not captured");
  a_span_outputs: assert property ( // RL1
    ##1 battery_voltage_span_sel == $past(vspan_reg) && adc_source_sel == $past(sel_reg))
    else $error("span or source output stale");

endmodule

/* File: rtl/conv_seq.sv */
// dual-slope converter sequencer: warm-up, integrate, timed de-integrate
// assumes cmp_high is synchronised and stays high until the ramp crosses
module conv_seq #(
  parameter int WARM_CYC = adc_irq_pkg::WARMUP_CYC,
  parameter int INT_CYC = adc_irq_pkg::INTEGRATE_CYC,
  parameter int STEP_CYC = adc_irq_pkg::STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic enable,
  input wire logic start,
  input wire logic cmp_high,
  output logic integ,
  output logic deint,
  output logic busy,
  output logic done,
  output logic ovf,
  output logic [7:0] code
);
  import adc_irq_pkg::*;

  conv_state_t st_reg;
  logic [15:0] cnt_reg;
  logic [7:0] acc_reg;
  logic pend_reg;

  // ----------------------------------------------------------------
  // phase sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_reg <= CV_OFF;
      cnt_reg <= 16'h0000;
      acc_reg <= 8'h00;
      pend_reg <= 1'b0;
      integ <= 1'b0;
      deint <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      ovf <= 1'b0;
      code <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      if (!enable)
      begin
        st_reg <= CV_OFF;
        pend_reg <= 1'b0;
        integ <= 1'b0;
        deint <= 1'b0;
        busy <= 1'b0;
      end
      else
      begin
        case (st_reg)
          CV_OFF:
          begin
            st_reg <= CV_WARM;
            cnt_reg <= 16'h0000;
          end
          CV_WARM:
          begin
            // a start during warm-up waits for it to finish
            if (start)
            begin
              pend_reg <= 1'b1;
              busy <= 1'b1;
            end
            if (cnt_reg == 16'(WARM_CYC - 1))
            begin
              st_reg <= CV_READY;
              cnt_reg <= 16'h0000;
            end
            else
              cnt_reg <= cnt_reg + 16'h0001;
          end
          CV_READY:
          begin
            if (start || pend_reg)
            begin
              st_reg <= CV_INTEG;
              cnt_reg <= 16'h0000;
              pend_reg <= 1'b0;
              integ <= 1'b1;
              busy <= 1'b1;
            end
          end
          CV_INTEG:
          begin
            if (cnt_reg == 16'(INT_CYC - 1))
            begin
              st_reg <= CV_DEINT;
              cnt_reg <= 16'h0000;
              acc_reg <= 8'h00;
              integ <= 1'b0;
              deint <= 1'b1;
            end
            else
              cnt_reg <= cnt_reg + 16'h0001;
          end
          CV_DEINT:
          begin
            if (!cmp_high)
            begin
              st_reg <= CV_READY;
              deint <= 1'b0;
              busy <= 1'b0;
              done <= 1'b1;
              ovf <= 1'b0;
              code <= acc_reg;
            end
            else if (cnt_reg == 16'(STEP_CYC - 1))
            begin
              cnt_reg <= 16'h0000;
              if (acc_reg == 8'hff)
              begin
                st_reg <= CV_READY;
                deint <= 1'b0;
                busy <= 1'b0;
                done <= 1'b1;
                ovf <= 1'b1;
                code <= 8'hff;
              end
              else
                acc_reg <= acc_reg + 8'h01;
            end
            else
              cnt_reg <= cnt_reg + 16'h0001;
          end
          default:
            st_reg <= CV_OFF;
        endcase
      end
    end
  end

endmodule

/* File: rtl/pin_sync.sv */
// three-stage input synchroniser with agreement filter
// assumes asynchronous inputs; output follows when stages two and three agree
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q <= INIT;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q <= (s2_reg & ~(s2_reg ^ s3_reg)) | (q & (s2_reg ^ s3_reg));
    end
  end

endmodule
